// ---- hw/burst_sram_pkg.sv ----
package burst_sram_pkg;

	// ==========================================================
	// Geometry
	localparam int WORD_W       = 18;
	localparam int LANE_W       = 9;
	localparam int LANES        = 2;
	localparam int BURST_LEN    = 4;
	localparam int ARRAY_ADDR_W = 19;
	localparam int SYNC_STAGES  = 3;

	// ==========================================================
	// Read latency in half clock periods (one sys_clk edge each)
	localparam int LATENCY_HALF_FULL   = 5;
	localparam int LATENCY_HALF_LEGACY = 2;
	// Buffer and fetch stage take two of those half periods
	localparam logic [1:0] FETCH_DELAY_FULL   = 2'(LATENCY_HALF_FULL - 2);
	localparam logic [1:0] FETCH_DELAY_LEGACY = 2'(LATENCY_HALF_LEGACY - 2);

	// ==========================================================
	// Reset values
	localparam logic [SYNC_STAGES-1:0] PLL_SYNC_RESET = 3'h7;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		GRANT_IDLE  = 2'b00,
		GRANT_READ  = 2'b01,
		GRANT_WRITE = 2'b10
	} grant_t;

	typedef struct packed {
		logic [WORD_W-1:0] data;
		logic [LANES-1:0]  laneEn;
	} write_word_t;

endpackage : burst_sram_pkg

// ---- hw/word_array.sv ----
module word_array #(
	parameter int ADDR_W = burst_sram_pkg::ARRAY_ADDR_W
) (
	input  wire logic                              sys_clk,
	input  wire logic                              writeEn,
	input  wire logic [ADDR_W-1:0]                 writeAddr,
	input  wire logic [burst_sram_pkg::LANES-1:0]  laneEn,
	input  wire logic [burst_sram_pkg::WORD_W-1:0] writeWord,
	input  wire logic [ADDR_W-1:0]                 readAddr,
	output logic      [burst_sram_pkg::WORD_W-1:0] readWord
);

	// ==========================================================
	// Storage, one word per entry, written lane by lane
	logic [burst_sram_pkg::WORD_W-1:0] mem [2**ADDR_W];

	// Lanes left disabled keep their stored contents
	always_ff @(posedge sys_clk) begin
		for (int l = 0; l < burst_sram_pkg::LANES; l++) begin
			if (writeEn && laneEn[l]) begin
				mem[writeAddr][l*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] <=
					writeWord[l*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W];
			end
		end
	end

	assign readWord = mem[readAddr];

endmodule : word_array

// ---- hw/two_entry_buffer.sv ----
module two_entry_buffer #(
	parameter int WIDTH = burst_sram_pkg::WORD_W
) (
	input  wire logic             sys_clk,
	input  wire logic             rstN,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady
);

	// ==========================================================
	// Output register plus one skid entry
	logic             skidValid;
	logic [WIDTH-1:0] skidData;
	logic             next_outValid;
	logic [WIDTH-1:0] next_outData;
	logic             next_skidValid;
	logic [WIDTH-1:0] next_skidData;

	// Full when the skid entry holds a word
	assign inReady = !skidValid;

	always_comb begin
		next_outValid  = outValid;
		next_outData   = outData;
		next_skidValid = skidValid;
		next_skidData  = skidData;
		if (!outValid || outReady) begin
			if (skidValid) begin
				next_outValid  = 1'b1;
				next_outData   = skidData;
				next_skidValid = 1'b0;
			end else begin
				next_outValid = inValid;
				next_outData  = inData;
			end
		end else if (inValid && !skidValid) begin
			next_skidValid = 1'b1;
			next_skidData  = inData;
		end
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			outValid  <= 1'b0;
			outData   <= '0;
			skidValid <= 1'b0;
			skidData  <= '0;
		end else begin
			outValid  <= next_outValid;
			outData   <= next_outData;
			skidValid <= next_skidValid;
			skidData  <= next_skidData;
		end
	end

endmodule : two_entry_buffer

// ---- hw/dual_port_burst_sram_core.sv ----
module dual_port_burst_sram_core #(
	parameter int ADDR_W = burst_sram_pkg::ARRAY_ADDR_W
) (
	input  wire logic                                   sys_clk,
	input  wire logic                                   resetn,
	input  wire logic                                   kRise,
	input  wire logic                                   pllDisableN,
	input  wire logic                                   readPortSelectN,
	input  wire logic                                   writePortSelectN,
	input  wire logic [burst_sram_pkg::LANES-1:0]       byteLaneWriteSelectN,
	input  wire logic [ADDR_W-1:0]                      address,
	input  wire logic [burst_sram_pkg::WORD_W-1:0]      writeData,
	input  wire logic                                   readReady,
	output logic      [burst_sram_pkg::WORD_W-1:0]      q,
	output logic                                        qOe
);

	// ==========================================================
	// Reset release
	logic rstMeta;
	logic rstSyncN;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta  <= 1'b0;
			rstSyncN <= 1'b0;
		end else begin
			rstMeta  <= 1'b1;
			rstSyncN <= rstMeta;
		end
	end

	// ==========================================================
	// Latency mode from the PLL strap
	logic [burst_sram_pkg::SYNC_STAGES-1:0] pllSync;
	logic [burst_sram_pkg::SYNC_STAGES-1:0] next_pllSync;
	logic                                   legacyMode;
	logic                                   next_legacyMode;

	always_comb begin
		next_pllSync    = {pllSync[1:0], pllDisableN};
		next_legacyMode = legacyMode;
		if (pllSync[1] == pllSync[2]) begin
			next_legacyMode = !pllSync[2];
		end
	end

	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			pllSync    <= burst_sram_pkg::PLL_SYNC_RESET;
			legacyMode <= 1'b0;
		end else begin
			pllSync    <= next_pllSync;
			legacyMode <= next_legacyMode;
		end
	end

	// ==========================================================
	// Request arbitration
	burst_sram_pkg::grant_t lastGrant;
	burst_sram_pkg::grant_t next_lastGrant;
	logic                   readOk;
	logic                   writeOk;
	logic                   transfer;
	logic                   fetchFree;
	logic                   waitValid;
	logic                   wAccD;
	logic                   burstActive;
	logic [1:0]             burstIdx;
	logic                   bufInReady;

	assign readOk  = kRise && !readPortSelectN && lastGrant != burst_sram_pkg::GRANT_READ &&
	                 (!waitValid || transfer);
	assign writeOk = kRise && !writePortSelectN && lastGrant != burst_sram_pkg::GRANT_WRITE && !readOk;

	always_comb begin
		next_lastGrant = lastGrant;
		if (kRise) begin
			unique case ({readOk, writeOk})
				2'b10: next_lastGrant = burst_sram_pkg::GRANT_READ;
				2'b01: next_lastGrant = burst_sram_pkg::GRANT_WRITE;
				2'b00: next_lastGrant = burst_sram_pkg::GRANT_IDLE;
				default: next_lastGrant = burst_sram_pkg::GRANT_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			lastGrant <= burst_sram_pkg::GRANT_IDLE;
		end else begin
			lastGrant <= next_lastGrant;
		end
	end

	// ==========================================================
	// Read address register and burst fetch engine
	logic [ADDR_W-1:0] waitAddr;
	logic [1:0]        waitCnt;
	logic [ADDR_W-1:0] burstAddr;
	logic              next_waitValid;
	logic [ADDR_W-1:0] next_waitAddr;
	logic [1:0]        next_waitCnt;
	logic              next_burstActive;
	logic [ADDR_W-1:0] next_burstAddr;
	logic [1:0]        next_burstIdx;
	logic              waitFwd;
	logic              burstFwd;
	logic              next_waitFwd;
	logic              next_burstFwd;

	// Next burst starts as the last word of the previous one leaves
	assign fetchFree = !burstActive || (burstIdx == 2'h3 && bufInReady);
	assign transfer  = waitValid && waitCnt == 2'h0 && fetchFree;

	always_comb begin
		next_waitValid   = waitValid;
		next_waitAddr    = waitAddr;
		next_waitCnt     = waitCnt;
		next_burstActive = burstActive;
		next_burstAddr   = burstAddr;
		next_burstIdx    = burstIdx;
		next_waitFwd     = waitFwd;
		next_burstFwd    = burstFwd;
		if (transfer) begin
			next_waitValid = 1'b0;
		end else if (waitValid && waitCnt != 2'h0) begin
			next_waitCnt = waitCnt - 2'h1;
		end
		// A collection starting after the read was taken holds newer data
		if (wAccD) begin
			next_waitFwd  = 1'b0;
			next_burstFwd = 1'b0;
		end
		if (readOk) begin
			next_waitValid = 1'b1;
			next_waitFwd   = 1'b1;
			next_waitAddr  = address;
			next_waitCnt   = legacyMode ? burst_sram_pkg::FETCH_DELAY_LEGACY : burst_sram_pkg::FETCH_DELAY_FULL;
		end
		if (burstActive && bufInReady) begin
			next_burstIdx = burstIdx + 2'h1;
			if (burstIdx == 2'h3) begin
				next_burstActive = 1'b0;
			end
		end
		if (transfer) begin
			next_burstActive = 1'b1;
			next_burstAddr   = waitAddr;
			next_burstIdx    = 2'h0;
			next_burstFwd    = waitFwd && !wAccD;
		end
	end

	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			waitValid   <= 1'b0;
			waitAddr    <= '0;
			waitCnt     <= 2'h0;
			burstActive <= 1'b0;
			burstAddr   <= '0;
			burstIdx    <= 2'h0;
			waitFwd     <= 1'b0;
			burstFwd    <= 1'b0;
		end else begin
			waitValid   <= next_waitValid;
			waitAddr    <= next_waitAddr;
			waitCnt     <= next_waitCnt;
			burstActive <= next_burstActive;
			burstAddr   <= next_burstAddr;
			burstIdx    <= next_burstIdx;
			waitFwd     <= next_waitFwd;
			burstFwd    <= next_burstFwd;
		end
	end

	// ==========================================================
	// Write capture
	// Address waits in pendAddr so a new write can be accepted while
	// the previous burst still collects its last two words.
	burst_sram_pkg::write_word_t slot      [burst_sram_pkg::BURST_LEN];
	burst_sram_pkg::write_word_t next_slot [burst_sram_pkg::BURST_LEN];
	logic                                 wAcc;
	logic [ADDR_W-1:0]                    pendAddr;
	logic [ADDR_W-1:0]                    collectAddr;
	logic                                 collecting;
	logic [1:0]                           wIdx;
	logic [burst_sram_pkg::BURST_LEN-1:0] filled;
	logic                                 commitPending;
	logic                                 captureNow;
	logic [1:0]                           capIdx;
	logic [ADDR_W-1:0]                    next_pendAddr;
	logic [ADDR_W-1:0]                    next_collectAddr;
	logic                                 next_collecting;
	logic [1:0]                           next_wIdx;
	logic [burst_sram_pkg::BURST_LEN-1:0] next_filled;
	logic                                 next_commitPending;

	assign captureNow = wAccD || collecting;
	assign capIdx     = wAccD ? 2'h0 : wIdx;

	always_comb begin
		next_slot          = slot;
		next_pendAddr      = pendAddr;
		next_collectAddr   = collectAddr;
		next_collecting    = collecting;
		next_wIdx          = wIdx;
		next_filled        = filled;
		next_commitPending = 1'b0;
		if (writeOk) begin
			next_pendAddr = address;
		end
		if (commitPending) begin
			next_filled = '0;
		end
		if (captureNow) begin
			// Lane selects ride with each word
			next_slot[capIdx].data   = writeData;
			next_slot[capIdx].laneEn = ~byteLaneWriteSelectN;
			next_filled[capIdx]      = 1'b1;
			next_collecting          = capIdx != 2'h3;
			next_wIdx                = capIdx + 2'h1;
			next_commitPending       = capIdx == 2'h3;
			if (capIdx == 2'h0) begin
				next_collectAddr = pendAddr;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			for (int i = 0; i < burst_sram_pkg::BURST_LEN; i++) begin
				slot[i] <= '0;
			end
			wAcc          <= 1'b0;
			wAccD         <= 1'b0;
			pendAddr      <= '0;
			collectAddr   <= '0;
			collecting    <= 1'b0;
			wIdx          <= 2'h0;
			filled        <= '0;
			commitPending <= 1'b0;
		end else begin
			slot          <= next_slot;
			wAcc          <= writeOk;
			wAccD         <= wAcc;
			pendAddr      <= next_pendAddr;
			collectAddr   <= next_collectAddr;
			collecting    <= next_collecting;
			wIdx          <= next_wIdx;
			filled        <= next_filled;
			commitPending <= next_commitPending;
		end
	end

	// ==========================================================
	// Arrays, forwarding and output buffer
	logic [burst_sram_pkg::WORD_W-1:0] rdWord [burst_sram_pkg::BURST_LEN];
	logic [burst_sram_pkg::WORD_W-1:0] fetchWord;

	for (genvar i = 0; i < burst_sram_pkg::BURST_LEN; i++) begin : g_array
		word_array #(
			.ADDR_W(ADDR_W)
		) u_array (
			.sys_clk   (sys_clk),
			.writeEn   (commitPending),
			.writeAddr (collectAddr),
			.laneEn    (slot[i].laneEn),
			.writeWord (slot[i].data),
			.readAddr  (burstAddr),
			.readWord  (rdWord[i])
		);
	end

	// Lane l covers bits l*9 upward
	always_comb begin
		fetchWord = rdWord[burstIdx];
		for (int l = 0; l < burst_sram_pkg::LANES; l++) begin
			if (burstFwd && filled[burstIdx] && collectAddr == burstAddr && slot[burstIdx].laneEn[l]) begin
				fetchWord[l*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] =
					slot[burstIdx].data[l*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W];
			end
		end
	end

	two_entry_buffer #(
		.WIDTH(burst_sram_pkg::WORD_W)
	) u_out_buffer (
		.sys_clk  (sys_clk),
		.rstN     (rstSyncN),
		.inValid  (burstActive),
		.inData   (fetchWord),
		.inReady  (bufInReady),
		.outValid (qOe),
		.outData  (q),
		.outReady (readReady)
	);

	// ==========================================================
	// Checks
	property p_read_spacing;
		@(posedge sys_clk) disable iff (!rstSyncN)
		readOk |-> ##2 !readOk;
	endproperty
	a_read_spacing: assert property (p_read_spacing) else $error("read accepted on consecutive K rises");

	property p_write_spacing;
		@(posedge sys_clk) disable iff (!rstSyncN)
		writeOk |-> ##2 !writeOk;
	endproperty
	a_write_spacing: assert property (p_write_spacing) else $error("write accepted on consecutive K rises");

	property p_full_latency;
		@(posedge sys_clk) disable iff (!rstSyncN)
		(readOk && !legacyMode && !qOe && !burstActive && !waitValid) |-> !qOe [*6] ##1 qOe;
	endproperty
	a_full_latency: assert property (p_full_latency) else $error("full mode read data not at five half periods");

	property p_legacy_latency;
		@(posedge sys_clk) disable iff (!rstSyncN)
		(readOk && legacyMode && !qOe && !burstActive && !waitValid) |-> ##3 qOe;
	endproperty
	a_legacy_latency: assert property (p_legacy_latency) else $error("legacy read data not at two half periods");

	property p_burst_start;
		@(posedge sys_clk) disable iff (!rstSyncN)
		transfer |=> burstActive && burstIdx == 2'h0 && burstAddr == $past(waitAddr);
	endproperty
	a_burst_start: assert property (p_burst_start) else $error("burst did not start at lowest word");

	property p_no_gap;
		@(posedge sys_clk) disable iff (!rstSyncN)
		(burstActive && burstIdx == 2'h3 && bufInReady && waitValid && waitCnt == 2'h0)
			|=> burstActive && burstIdx == 2'h0;
	endproperty
	a_no_gap: assert property (p_no_gap) else $error("next burst did not follow without a gap");

	property p_write_collect;
		@(posedge sys_clk) disable iff (!rstSyncN)
		writeOk |-> ##2 captureNow [*4] ##1 commitPending && collectAddr == $past(pendAddr, 4);
	endproperty
	a_write_collect: assert property (p_write_collect) else $error("write burst not captured and committed");

	property p_read_first;
		@(posedge sys_clk) disable iff (!rstSyncN)
		(kRise && !readPortSelectN && !writePortSelectN && lastGrant == burst_sram_pkg::GRANT_IDLE && !waitValid)
			|-> readOk ##2 (!kRise || writePortSelectN || writeOk);
	endproperty
	a_read_first: assert property (p_read_first) else $error("arbitration did not alternate from read");

	property p_release;
		@(posedge sys_clk) disable iff (!rstSyncN)
		(!burstActive && !waitValid && readReady) [*3] |=> !qOe;
	endproperty
	a_release: assert property (p_release) else $error("read outputs still driven after drain");

endmodule : dual_port_burst_sram_core

// ---- testbench/mem_controller_model.sv ----
module mem_controller_model #(
	parameter int ADDR_W = 4
) (
	input  wire logic                              sys_clk,
	output logic                                   kRise,
	output logic                                   readPortSelectN,
	output logic                                   writePortSelectN,
	output logic      [burst_sram_pkg::LANES-1:0]  byteLaneWriteSelectN,
	output logic      [ADDR_W-1:0]                 address,
	output logic      [burst_sram_pkg::WORD_W-1:0] writeData
);
	timeunit 1ns;
	timeprecision 1ns;

	int                                cyc = 0;
	logic                              cmdValid = 1'h0;
	logic                              cmdRdN;
	logic                              cmdWrN;
	logic                              cmdData;
	logic [ADDR_W-1:0]                 cmdAddr;
	burst_sram_pkg::write_word_t [3:0] cmdWords;
	burst_sram_pkg::write_word_t       wordQ[$];
	int                                atQ[$];

	initial begin
		kRise                = 1'h0;
		readPortSelectN      = 1'h1;
		writePortSelectN     = 1'h1;
		byteLaneWriteSelectN = 2'h0;
		address              = '0;
		writeData            = 18'h0;
	end

	always @(posedge sys_clk) cyc <= cyc + 1;

	// ==========================================================
	// Pin driver
	always @(negedge sys_clk) begin
		kRise <= ~kRise;
		if (!kRise && cmdValid) begin
			readPortSelectN  <= cmdRdN;
			writePortSelectN <= cmdWrN;
			address          <= cmdAddr;
			for (int k = 0; k < 4; k++) begin
				if (cmdData) begin
					wordQ.push_back(cmdWords[k]);
					atQ.push_back(cyc + 2 + k);
				end
			end
			cmdValid = 1'h0;
		end else begin
			readPortSelectN  <= 1'h1;
			writePortSelectN <= 1'h1;
			address          <= ~address;
		end
		// Toggle outside bursts so stale data can never pass for fresh
		if (atQ.size() > 0 && atQ[0] == cyc) begin
			writeData            <= wordQ[0].data;
			byteLaneWriteSelectN <= ~wordQ[0].laneEn;
			void'(wordQ.pop_front());
			void'(atQ.pop_front());
		end else begin
			writeData            <= ~writeData;
			byteLaneWriteSelectN <= ~byteLaneWriteSelectN;
		end
	end

	task automatic slot(input logic rdN, input logic wrN, input logic [ADDR_W-1:0] a, input logic data,
			input burst_sram_pkg::write_word_t [3:0] w);
		cmdRdN   = rdN;
		cmdWrN   = wrN;
		cmdAddr  = a;
		cmdData  = data;
		cmdWords = w;
		cmdValid = 1'h1;
		wait (!cmdValid);
		@(posedge sys_clk);
	endtask : slot

endmodule : mem_controller_model

// ---- testbench/tb_dual_port_burst_sram_core.sv ----
module tb_dual_port_burst_sram_core;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int AW = 4;

	logic                              sys_clk;
	logic                              resetn;
	logic                              kRise;
	logic                              pllDisableN;
	logic                              readPortSelectN;
	logic                              writePortSelectN;
	logic [burst_sram_pkg::LANES-1:0]  byteLaneWriteSelectN;
	logic [AW-1:0]                     address;
	logic [burst_sram_pkg::WORD_W-1:0] writeData;
	logic                              readReady;
	logic [burst_sram_pkg::WORD_W-1:0] q;
	logic                              qOe;
	logic [burst_sram_pkg::WORD_W-1:0] mem [2**AW][4];
	logic [burst_sram_pkg::WORD_W-1:0] expQ[$];
	logic [31:0]                       seed = 32'h13D98835;
	logic                              stall = 1'h0;
	int                                n_errors = 0;
	int                                n_checks = 0;
	int                                cycles = 0;
	int                                run = 0;
	int                                maxRun = 0;

	dual_port_burst_sram_core #(.ADDR_W(AW)) dut (.sys_clk(sys_clk), .resetn(resetn), .kRise(kRise),
		.pllDisableN(pllDisableN), .readPortSelectN(readPortSelectN), .writePortSelectN(writePortSelectN),
		.byteLaneWriteSelectN(byteLaneWriteSelectN), .address(address), .writeData(writeData),
		.readReady(readReady), .q(q), .qOe(qOe));

	mem_controller_model #(.ADDR_W(AW)) ctl (.sys_clk(sys_clk), .kRise(kRise),
		.readPortSelectN(readPortSelectN), .writePortSelectN(writePortSelectN),
		.byteLaneWriteSelectN(byteLaneWriteSelectN), .address(address), .writeData(writeData));

	initial begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [17:0] merge(input logic [17:0] old, input burst_sram_pkg::write_word_t w);
		return {w.laneEn[1] ? w.data[17:9] : old[17:9], w.laneEn[0] ? w.data[8:0] : old[8:0]};
	endfunction : merge

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		$display("Checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	task automatic wr(input logic [AW-1:0] a, input logic full, input logic both);
		burst_sram_pkg::write_word_t [3:0] w;
		for (int k = 0; k < 4; k++) begin
			w[k].data   = 18'(rnd());
			w[k].laneEn = full ? 2'h3 : 2'(rnd());
			mem[a][k]   = merge(mem[a][k], w[k]);
		end
		ctl.slot(both ? 1'h0 : 1'h1, 1'h0, a, 1'h1, w);
	endtask : wr

	task automatic rd(input logic [AW-1:0] a, input logic both);
		for (int k = 0; k < 4; k++)
			expQ.push_back(mem[a][k]);
		ctl.slot(1'h0, both ? 1'h0 : 1'h1, a, 1'h0, '0);
	endtask : rd

	task automatic nop();
		ctl.slot(1'h1, 1'h1, '0, 1'h0, '0);
	endtask : nop

	task automatic drain();
		for (int i = 0; i < 200 && expQ.size() > 0; i++)
			@(posedge sys_clk);
		repeat (6) @(posedge sys_clk);
		check("words left", expQ.size(), 0);
		check("output enable idle", qOe, 0);
	endtask : drain

	task automatic latency(input int expEdges);
		int n = 0;
		rd(AW'(rnd()), 1'h0);
		while (qOe !== 1'h1 && n < 20) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		check("read latency", n, expEdges);
	endtask : latency

	// ==========================================================
	// Read port monitor and timeout
	always @(negedge sys_clk) readReady <= stall ? ^rnd() : 1'h1;

	always @(posedge sys_clk) begin
		cycles++;
		if (qOe === 1'h1 && readReady === 1'h1) begin
			if (expQ.size() == 0)
				check("unexpected word", 1, 0);
			else
				check("read word", q, expQ.pop_front());
		end
		run = (qOe === 1'h1) ? run + 1 : 0;
		if (run > maxRun)
			maxRun = run;
		if (cycles == 6000) begin
			n_errors++;
			print_verdict();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		resetn      = 1'h0;
		pllDisableN = 1'h1;
		readReady   = 1'h1;
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk);
		resetn = 1'h1;
		repeat (8) @(posedge sys_clk);
		check("output enable reset", qOe, 0);
		for (int i = 0; i < 2**AW; i++) begin
			wr(AW'(i), 1'h1, 1'h0);
			nop();
		end
		drain();
		latency(burst_sram_pkg::LATENCY_HALF_FULL);
		drain();
		for (int i = 0; i < 40; i++) begin
			wr(AW'(rnd()), 1'h0, 1'h0);
			rd(AW'(rnd()), 1'h0);
		end
		drain();
		nop();
		rd(AW'(5), 1'h0);
		ctl.slot(1'h0, 1'h1, AW'(6), 1'h0, '0);
		nop();
		wr(AW'(7), 1'h1, 1'h0);
		ctl.slot(1'h1, 1'h0, AW'(8), 1'h0, '0);
		nop();
		nop();
		rd(AW'(9), 1'h1);
		wr(AW'(10), 1'h0, 1'h1);
		nop();
		wr(AW'(11), 1'h0, 1'h0);
		rd(AW'(11), 1'h0);
		nop();
		drain();
		maxRun = 0;
		for (int i = 0; i < 2**AW; i++) begin
			rd(AW'(i), 1'h0);
			nop();
		end
		drain();
		check("gapless run", maxRun, 4 * 2**AW);
		// Receiver stalls at random, no word may be lost
		stall = 1'h1;
		rd(AW'(3), 1'h0);
		nop();
		repeat (40) @(posedge sys_clk);
		stall = 1'h0;
		drain();
		@(negedge sys_clk);
		pllDisableN = 1'h0;
		repeat (8) @(posedge sys_clk);
		latency(burst_sram_pkg::LATENCY_HALF_LEGACY);
		drain();
		// Legacy forwarding, a later write must not leak in
		wr(AW'(12), 1'h0, 1'h0);
		rd(AW'(12), 1'h0);
		wr(AW'(12), 1'h1, 1'h0);
		nop();
		drain();
		print_verdict();
	end

endmodule : tb_dual_port_burst_sram_core
